// ---- fre_fault_escalation.sv ----
`timescale 1ns/10ps
module fre_fault_escalation
   import fre_pkg::*;
#(
   parameter int NONMASKABLE_WATCHDOG_TIMEOUT = fre_pkg::NONMASKABLE_WATCHDOG_CYCLES,
   parameter int WARM_HOLD     = fre_pkg::WARM_HOLD_CYCLES
)
(
   // clock and reset
   input  wire logic                                    mclk_in,
   input  wire logic                                    rst_in,
   input  wire logic                                    power_on_reset_n_in,
   // warm reset open-drain pin
   input  wire logic                                    warm_reset_pin_n_in,
   output logic                                         warm_reset_pin_n_out,
   output logic                                         warm_reset_pin_n_oe_out,
   // fault sources
   input  wire logic [fre_pkg::NUM_CPU*fre_pkg::NUM_FAULT-1:0] nmi_fault_in,
   input  wire logic [fre_pkg::NUM_CPU-1:0]             nmi_ack_in,
   input  wire logic [fre_pkg::NUM_CPU-1:0]             security_violation_in,
   input  wire logic                                    watchdog_expire_in,
   input  wire logic                                    level2_fail_in,
   input  wire logic                                    critical_fault_in,
   input  wire logic                                    error_clear_in,
   // peripheral interrupts, per cpu
   input  wire logic [fre_pkg::NUM_CPU*fre_pkg::NUM_PIRQ-1:0] pirq_in,
   input  wire logic [fre_pkg::NUM_CPU*fre_pkg::NUM_PIRQ-1:0] pirq_enable_in,
   input  wire logic [fre_pkg::NUM_CPU*fre_pkg::NUM_PIRQ-1:0] pirq_ack_in,
   // cpu boot progress
   input  wire logic [fre_pkg::NUM_CPU-1:0]             boot_done_in,
   input  wire logic [fre_pkg::NUM_CPU-1:0]             app_start_in,
   // cpu side outputs
   output logic [fre_pkg::NUM_CPU-1:0]                  cpu_nmi_out,
   output logic [fre_pkg::NUM_CPU*fre_pkg::NUM_GRP-1:0] cpu_irq_out,
   output logic [fre_pkg::NUM_CPU-1:0]                  cpu_reset_out,
   output logic [fre_pkg::NUM_CPU*2-1:0]                cpu_phase_out,
   // system side outputs
   output logic                                         error_status_pin_out,
   output logic                                         gpio_hiz_out,
   output logic                                         power_down_req_out,
   output logic [2:0]                                   fault_response_out
);

   import fre_pkg::*;

   localparam int HW = $clog2(WARM_HOLD + 1);

   // per cpu wires
   logic [NUM_CPU-1:0]         nmi;
   logic [NUM_CPU-1:0]         nmi_set;
   logic [NUM_CPU-1:0]         nmi_expire;
   logic [NUM_CPU-1:0]         cpu_rst_req;
   logic [NUM_CPU*NUM_GRP-1:0] grp_req;
   logic [NUM_CPU*NUM_GRP-1:0] irq_d;

   // warm reset
   logic          ext_pull;
   logic          warm_cause;
   logic [HW-1:0] hold_q;
   logic [HW-1:0] hold_d;
   logic          warm_q;
   logic          warm_d;
   logic          warm_was_q;
   logic          cold_done;

   // status flops
   logic                       err_q;
   logic                       err_d;
   logic                       hiz_q;
   logic                       hiz_d;
   logic                       pd_q;
   logic                       pd_d;
   logic [NUM_CPU-1:0]         nmi_q;
   logic [NUM_CPU*NUM_GRP-1:0] irq_q;
   logic [NUM_CPU-1:0]         crst_q;
   logic [NUM_CPU-1:0]         crst_d;
   fre_resp_e                  resp_q;
   fre_resp_e                  resp_d;
   fre_phase_e                 phase_q [NUM_CPU];
   fre_phase_e                 phase_d [NUM_CPU];

   genvar c;
   generate
      for (c = 0; c < NUM_CPU; c++)
      begin : cpu
         // own nmi watchdog per cpu
         fre_nmi_wd #(
            .NUM_SRC    (NUM_FAULT),
            .TIMEOUT    (NONMASKABLE_WATCHDOG_TIMEOUT)
         ) u_nonmaskable_watchdog (
            .mclk_in    (mclk_in),
            .rst_in     (rst_in),
            .clear_in   (warm_q),
            .fault_in   (nmi_fault_in[c*NUM_FAULT +: NUM_FAULT]),
            .ack_in     (nmi_ack_in[c]),
            .nmi_out    (nmi[c]),
            .set_out    (nmi_set[c]),
            .expire_out (nmi_expire[c])
         );

         // interrupt expansion per cpu
         fre_int_expand #(
            .NUM_SRC     (NUM_PIRQ),
            .NUM_GRP     (NUM_GRP)
         ) u_expand (
            .mclk_in     (mclk_in),
            .rst_in      (rst_in),
            .clear_in    (warm_q),
            .src_in      (pirq_in[c*NUM_PIRQ +: NUM_PIRQ]),
            .enable_in   (pirq_enable_in[c*NUM_PIRQ +: NUM_PIRQ]),
            .ack_in      (pirq_ack_in[c*NUM_PIRQ +: NUM_PIRQ]),
            .grp_req_out (grp_req[c*NUM_GRP +: NUM_GRP]),
            .pending_out ()
         );

         // nmi holds off every maskable line
         assign irq_d[c*NUM_GRP +: NUM_GRP] = nmi[c] ? '0 : grp_req[c*NUM_GRP +: NUM_GRP];

         // security violation, or second cpu missing its nmi
         if (c == SECOND_CPU)
         begin : esc
            assign cpu_rst_req[c] = security_violation_in[c] | nmi_expire[c];
         end
         else
         begin : noesc
            assign cpu_rst_req[c] = security_violation_in[c];
         end

         assign crst_d[c] = cpu_rst_req[c];

         // operating phase walk
         always_comb
         begin
            phase_d[c] = phase_q[c];
            unique case (phase_q[c])
               FRE_PH_COLD:  if (cold_done) phase_d[c] = FRE_PH_WARM;
               FRE_PH_WARM:  if (boot_done_in[c]) phase_d[c] = FRE_PH_PREOP;
               FRE_PH_PREOP: if (app_start_in[c]) phase_d[c] = FRE_PH_OPER;
               FRE_PH_OPER:  phase_d[c] = FRE_PH_OPER;
            endcase
            if (cpu_rst_req[c] && phase_q[c] != FRE_PH_COLD)
               phase_d[c] = FRE_PH_WARM;
            if (warm_q)
               phase_d[c] = FRE_PH_COLD;
         end

         always_ff @(posedge mclk_in or posedge rst_in)
         begin
            if (rst_in)
               phase_q[c] <= FRE_PH_COLD;
            else
               phase_q[c] <= phase_d[c];
         end

         assign cpu_phase_out[c*2 +: 2] = phase_q[c];
      end
   endgenerate

   // outside pull only counts while we are not driving
   assign ext_pull = ~warm_reset_pin_n_in & ~warm_q;

   // warm reset causes
   assign warm_cause = ~power_on_reset_n_in
                     | watchdog_expire_in
                     | nmi_expire[MASTER_CPU]
                     | ext_pull;

   assign hold_d    = warm_cause ? HW'(WARM_HOLD) : ((hold_q != '0) ? hold_q - HW'(1) : '0);
   assign warm_d    = warm_cause | (hold_q > HW'(1));
   assign cold_done = warm_was_q & ~warm_q;

   // error status, set wins over clear
   assign err_d = (|nmi_set) | level2_fail_in | (err_q & ~error_clear_in & ~warm_q);

   // actuator outputs released only by clear or reset
   assign hiz_d = level2_fail_in | (hiz_q & ~error_clear_in & ~warm_q);

   // supervisor asked to remove power, held until power-on reset asserts
   assign pd_d = critical_fault_in | (pd_q & power_on_reset_n_in);

   // most severe response present
   always_comb
   begin
      resp_d = FRE_RESP_NONE;
      if (|irq_d)
         resp_d = FRE_RESP_CPU_INT;
      if (|nmi)
         resp_d = FRE_RESP_NMI;
      if (|crst_d)
         resp_d = FRE_RESP_CPU_RST;
      if (warm_d)
         resp_d = FRE_RESP_WARM_RST;
      if (pd_d)
         resp_d = FRE_RESP_POWER_DOWN;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         hold_q <= '0;
      else
         hold_q <= hold_d;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         warm_q <= 1'b1;
      else
         warm_q <= warm_d;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         warm_was_q <= 1'b1;
      else
         warm_was_q <= warm_q;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         err_q <= 1'b0;
      else
         err_q <= err_d;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         hiz_q <= 1'b0;
      else
         hiz_q <= hiz_d;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         pd_q <= 1'b0;
      else
         pd_q <= pd_d;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         nmi_q <= '0;
      else
         nmi_q <= nmi;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         irq_q <= '0;
      else
         irq_q <= irq_d;
   end

   // cpu reset pulses, also held through the whole warm reset
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         crst_q <= '1;
      else
         crst_q <= crst_d | {NUM_CPU{warm_d}};
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         resp_q <= FRE_RESP_NONE;
      else
         resp_q <= resp_d;
   end

   // pin level is always low, enable carries the reset
   assign warm_reset_pin_n_out    = 1'b0;
   assign warm_reset_pin_n_oe_out = warm_q;
   assign cpu_nmi_out             = nmi_q;
   assign cpu_irq_out             = irq_q;
   assign cpu_reset_out           = crst_q;
   assign error_status_pin_out    = err_q;
   assign gpio_hiz_out            = hiz_q;
   assign power_down_req_out      = pd_q;
   assign fault_response_out      = resp_q;

endmodule

// ---- fre_pkg.sv ----
package fre_pkg;

   // device shape
   localparam int NUM_CPU    = 2;
   localparam int MASTER_CPU = 0;
   localparam int SECOND_CPU = 1;
   localparam int NUM_FAULT  = 8;
   localparam int NUM_PIRQ   = 32;
   localparam int NUM_GRP    = 4;

   // clock rate
   localparam int CLK_MHZ = 250;

   // nmi watchdog service window, rounded down to whole cycles
   localparam int NONMASKABLE_WATCHDOG_TIMEOUT_NS = 4000;
   localparam int NONMASKABLE_WATCHDOG_CYCLES     = (NONMASKABLE_WATCHDOG_TIMEOUT_NS * CLK_MHZ) / 1000;

   // least warm reset pin hold, rounded up to whole cycles
   localparam int WARM_HOLD_NS     = 1000;
   localparam int WARM_HOLD_CYCLES = (WARM_HOLD_NS * CLK_MHZ + 999) / 1000;

   // fault responses, least to most severe
   typedef enum logic [2:0] {
      FRE_RESP_NONE,
      FRE_RESP_CPU_INT,
      FRE_RESP_NMI,
      FRE_RESP_CPU_RST,
      FRE_RESP_WARM_RST,
      FRE_RESP_POWER_DOWN
   } fre_resp_e;

   // cpu operating phases
   typedef enum logic [1:0] {
      FRE_PH_COLD,
      FRE_PH_WARM,
      FRE_PH_PREOP,
      FRE_PH_OPER
   } fre_phase_e;

endpackage

// ---- fre_nmi_wd.sv ----
`timescale 1ns/10ps
module fre_nmi_wd
#(
   parameter int NUM_SRC = 8,
   parameter int TIMEOUT = 1000
)
(
   // clock and reset
   input  wire logic               mclk_in,
   input  wire logic               rst_in,
   input  wire logic               clear_in,
   // fault sources and service
   input  wire logic [NUM_SRC-1:0] fault_in,
   input  wire logic               ack_in,
   // nmi and expiry
   output logic                    nmi_out,
   output logic                    set_out,
   output logic                    expire_out
);

   localparam int CW = $clog2(TIMEOUT + 1);

   logic [NUM_SRC-1:0] flags_q;
   logic [NUM_SRC-1:0] flags_d;
   logic [CW-1:0]      cnt_q;
   logic [CW-1:0]      cnt_d;
   logic               fired_q;
   logic               fired_d;
   logic               pending;
   logic               hit;

   // sticky fault flags, a new fault wins over the service clear
   assign flags_d = clear_in ? '0 : (fault_in | (flags_q & {NUM_SRC{~ack_in}}));
   assign pending = |flags_q;
   assign hit     = pending & ~fired_q & (cnt_q == CW'(TIMEOUT - 1));
   assign cnt_d   = (clear_in | ack_in | ~pending) ? '0 : (fired_q ? cnt_q : cnt_q + CW'(1));
   assign fired_d = (clear_in | ack_in) ? 1'b0 : (fired_q | hit);

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         flags_q <= '0;
         cnt_q   <= '0;
         fired_q <= 1'b0;
      end
      else
      begin
         flags_q <= flags_d;
         cnt_q   <= cnt_d;
         fired_q <= fired_d;
      end
   end

   assign nmi_out    = pending;
   assign set_out    = |(fault_in & ~flags_q);
   assign expire_out = hit;

endmodule

// ---- fre_int_expand.sv ----
`timescale 1ns/10ps
module fre_int_expand
#(
   parameter int NUM_SRC = 32,
   parameter int NUM_GRP = 4
)
(
   // clock and reset
   input  wire logic               mclk_in,
   input  wire logic               rst_in,
   input  wire logic               clear_in,
   // peripheral sources
   input  wire logic [NUM_SRC-1:0] src_in,
   input  wire logic [NUM_SRC-1:0] enable_in,
   input  wire logic [NUM_SRC-1:0] ack_in,
   // cpu interrupt lines
   output logic [NUM_GRP-1:0]      grp_req_out,
   output logic [NUM_SRC-1:0]      pending_out
);

   localparam int PER_GRP = NUM_SRC / NUM_GRP;

   logic [NUM_SRC-1:0] pend_q;
   logic [NUM_SRC-1:0] pend_d;
   logic [NUM_SRC-1:0] live;

   // pending latches, a new request wins over its acknowledge
   assign pend_d = clear_in ? '0 : (src_in | (pend_q & ~ack_in));
   assign live   = pend_q & enable_in;

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         pend_q <= '0;
      else
         pend_q <= pend_d;
   end

   // many sources folded onto fewer cpu lines
   genvar g;
   generate
      for (g = 0; g < NUM_GRP; g++)
      begin : grp
         assign grp_req_out[g] = |live[g*PER_GRP +: PER_GRP];
      end
   endgenerate

   assign pending_out = pend_q;

endmodule

// ---- fre_fault_escalation_props.sv ----
`timescale 1ns/10ps
module fre_fault_escalation_chk
   import fre_pkg::*;
#(
   parameter int NONMASKABLE_WATCHDOG_TIMEOUT = 8,
   parameter int WARM_HOLD     = 4
)
(
   // clock, reset and causes
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        power_on_reset_n_in,
   input wire logic        warm_reset_pin_n_in,
   input wire logic [15:0] nmi_fault_in,
   input wire logic [1:0]  security_violation_in,
   input wire logic        watchdog_expire_in,
   input wire logic        level2_fail_in,
   input wire logic        critical_fault_in,
   input wire logic        error_clear_in,
   // responses watched
   input wire logic        warm_reset_pin_n_oe_out,
   input wire logic [1:0]  cpu_nmi_out,
   input wire logic [7:0]  cpu_irq_out,
   input wire logic [1:0]  cpu_reset_out,
   input wire logic [3:0]  cpu_phase_out,
   input wire logic        error_status_pin_out,
   input wire logic        gpio_hiz_out,
   input wire logic        power_down_req_out,
   input wire logic [2:0]  fault_response_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // any warm reset cause but master nmi expiry, or warm reset already under way
   wire wr_any = warm_reset_pin_n_oe_out | ~warm_reset_pin_n_in | ~power_on_reset_n_in | watchdog_expire_in;
   sequence s_fault_m;
      nmi_fault_in[7:0] != 8'h00 && !wr_any;
   endsequence
   sequence s_nmi_m;
      ##1 (cpu_nmi_out[0] || warm_reset_pin_n_oe_out);
   endsequence
   a_nmi_err_pin: assert property (
      |nmi_fault_in && !wr_any |=> error_status_pin_out || warm_reset_pin_n_oe_out)
      else $error("error pin missing after nmi fault");
   a_nmi_master_out: assert property (s_fault_m |=> s_nmi_m)
      else $error("master nmi missing");
   a_nmi_masks_irq: assert property (
      !(cpu_nmi_out[0] && |cpu_irq_out[3:0]) && !(cpu_nmi_out[1] && |cpu_irq_out[7:4]))
      else $error("irq line high beside nmi");
   a_secv_cpu_rst: assert property (security_violation_in[1] |=> cpu_reset_out[1])
      else $error("no cpu reset after violation");
   a_rst_warm_boot: assert property (
      security_violation_in[1] && cpu_phase_out[3:2] >= FRE_PH_PREOP && !wr_any |=> cpu_phase_out[3:2] == FRE_PH_WARM)
      else $error("cpu reset did not return to warm boot");
   a_wdog_warm: assert property (watchdog_expire_in |=> warm_reset_pin_n_oe_out ##1 warm_reset_pin_n_oe_out)
      else $error("watchdog did not hold warm reset");
   a_por_warm: assert property (!power_on_reset_n_in |=> warm_reset_pin_n_oe_out && cpu_reset_out == 2'h3)
      else $error("power-on reset without warm reset");
   a_err_hold: assert property (
      error_status_pin_out && !error_clear_in && !wr_any |=> error_status_pin_out)
      else $error("error pin dropped early");
   a_l2_safe: assert property (level2_fail_in && !wr_any |=> gpio_hiz_out && error_status_pin_out)
      else $error("safe outputs not entered");
   a_crit_pwr: assert property (critical_fault_in |=> power_down_req_out && fault_response_out == 3'h5)
      else $error("power down not requested");
endmodule
bind fre_fault_escalation fre_fault_escalation_chk #(.NONMASKABLE_WATCHDOG_TIMEOUT(NONMASKABLE_WATCHDOG_TIMEOUT), .WARM_HOLD(WARM_HOLD)) chk_u (
   .mclk_in, .rst_in, .power_on_reset_n_in, .warm_reset_pin_n_in, .nmi_fault_in, .security_violation_in,
   .watchdog_expire_in, .level2_fail_in, .critical_fault_in, .error_clear_in, .warm_reset_pin_n_oe_out,
   .cpu_nmi_out, .cpu_irq_out, .cpu_reset_out, .cpu_phase_out, .error_status_pin_out, .gpio_hiz_out,
   .power_down_req_out, .fault_response_out);

// ---- fre_supervisor_model.sv ----
`timescale 1ns/10ps
module fre_supervisor_model
(
   // clock and reset
   input  wire logic mclk_in,
   input  wire logic rst_in,
   // pins watched and commands
   input  wire logic warm_oe_in,
   input  wire logic power_down_req_in,
   input  wire logic pull_low_in,
   // pins driven
   output logic      warm_pin_n_out,
   output logic      power_on_reset_n_out
);
   logic [3:0] off_q;
   logic [3:0] off_d;
   // pulled up wire, low while either side pulls
   assign warm_pin_n_out       = ~(warm_oe_in | pull_low_in);
   // supply cut for a few cycles on request, then restored for cold boot
   assign off_d                = (off_q != 4'h0) ? off_q - 4'h1 : (power_down_req_in ? 4'h6 : 4'h0);
   assign power_on_reset_n_out = (off_q == 4'h0);
   always_ff @(posedge mclk_in or posedge rst_in)
      if (rst_in)
         off_q <= 4'h0;
      else
         off_q <= off_d;
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
   import fre_pkg::*;
   localparam int NT = 8, WH = 4;
   // stimulus vector offsets
   localparam int PF = 0, PA = 16, PS = 18, PW = 20, PL = 21, PC = 22, PE = 23, PP = 24, PK = 88, PB = 152, PT = 154;
   logic         mclk_in, rst_in, pull_low;
   logic [155:0] pv;
   logic [63:0]  pen, p, en;
   wire          por_n, pin_n, oe, pin_o, err, hiz, pdr;
   wire  [1:0]   nmi, crst;
   wire  [7:0]   irq;
   wire  [3:0]   ph;
   wire  [2:0]   resp;
   int           num_errors, checks_done, seed;

   fre_fault_escalation #(.NONMASKABLE_WATCHDOG_TIMEOUT(NT), .WARM_HOLD(WH)) dut_u (
      .mclk_in(mclk_in), .rst_in(rst_in), .power_on_reset_n_in(por_n), .warm_reset_pin_n_in(pin_n),
      .warm_reset_pin_n_out(pin_o), .warm_reset_pin_n_oe_out(oe), .nmi_fault_in(pv[15:0]),
      .nmi_ack_in(pv[17:16]), .security_violation_in(pv[19:18]), .watchdog_expire_in(pv[20]),
      .level2_fail_in(pv[21]), .critical_fault_in(pv[22]), .error_clear_in(pv[23]), .pirq_in(pv[87:24]),
      .pirq_enable_in(pen), .pirq_ack_in(pv[151:88]), .boot_done_in(pv[153:152]), .app_start_in(pv[155:154]),
      .cpu_nmi_out(nmi), .cpu_irq_out(irq), .cpu_reset_out(crst), .cpu_phase_out(ph), .error_status_pin_out(err),
      .gpio_hiz_out(hiz), .power_down_req_out(pdr), .fault_response_out(resp));
   fre_supervisor_model sup_u (.mclk_in(mclk_in), .rst_in(rst_in), .warm_oe_in(oe), .power_down_req_in(pdr),
      .pull_low_in(pull_low), .warm_pin_n_out(pin_n), .power_on_reset_n_out(por_n));

   initial forever #2 mclk_in = ~mclk_in;

   function automatic logic [3:0] grp(input logic [31:0] v);
      for (int g = 0; g < 4; g++)
         grp[g] = |v[g*8+:8];
   endfunction

   task automatic close_out();
      if (num_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: return oe;
         1: return crst[1];
         default: return pdr;
      endcase
   endfunction

   task automatic wait_for(input int s, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && sig(s) !== v; i++)
         step(1);
      if (i == lim)
      begin
         num_errors++;
         close_out();
      end
   endtask

   // one-cycle pulse on the selected inputs
   task automatic pulse(input logic [155:0] v);
      @(posedge mclk_in);
      pv <= v;
      @(posedge mclk_in);
      pv <= '0;
      #1;
   endtask

   initial
   begin
      {mclk_in, pv, pen, pull_low, num_errors, checks_done} = '0;
      seed = 32'hADA9;
      rst_in = 1'b1;
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      wait_for(0, 1'b0, 10);
      step(1);
      chk("phase", ph, 8'h05);
      pulse(156'h3 << PB);
      pulse(156'h3 << PT);
      // boundary then random peripheral interrupts on both cpus
      for (int i = 0; i < 6; i++)
      begin
         p = (i == 0) ? 64'h8000_0001_0100_0080 : {$random(seed), $random(seed)};
         en = (i == 0) ? '1 : {$random(seed), $random(seed)};
         @(posedge mclk_in);
         pen <= en;
         pulse({92'h0, p} << PP);
         step(1);
         chk("irq", irq, {grp(p[63:32] & en[63:32]), grp(p[31:0] & en[31:0])});
         chk("resp", resp, (|(p & en)) ? 8'h01 : 8'h00);
         pulse({92'h0, 64'hFFFF_FFFF_FFFF_FFFF} << PK);
         step(1);
         chk("irq", irq, 8'h00);
      end
      @(posedge mclk_in);
      pen <= '1;
      pulse(156'h1 << PP);
      pulse(156'h80 << PF);
      chk("err", err, 8'h01);
      step(1);
      chk("nmi", {nmi, irq[3:0]}, 8'h10);
      chk("resp", resp, 8'h02);
      pulse(156'h1 << PA);
      step(2);
      chk("nmi", {nmi, irq[3:0]}, 8'h01);
      chk("err", err, 8'h01);
      pulse(156'h1 << PE);
      chk("err", err, 8'h00);
      pulse({92'h0, 64'hFFFF_FFFF_FFFF_FFFF} << PK);
      pulse(156'h2 << PS);
      chk("cpu reset", {crst, ph}, 8'h27);
      step(1);
      chk("cpu reset", crst, 8'h00);
      pulse(156'h2 << PB);
      pulse(156'h2 << PT);
      pulse(156'h100 << PF);
      wait_for(1, 1'b1, NT + 8);
      chk("second expiry", {oe, ph}, 8'h07);
      pulse(156'h2 << PA);
      pulse(156'h1 << PE);
      pulse(156'h1 << PF);
      wait_for(0, 1'b1, NT + 8);
      chk("master expiry", crst, 8'h03);
      chk("resp", resp, 8'h04);
      step(1);
      chk("master expiry", ph, 8'h00);
      wait_for(0, 1'b0, WH + 8);
      step(1);
      chk("after warm", {err, ph}, 8'h05);
      pulse(156'h1 << PW);
      chk("warm", oe, 8'h01);
      wait_for(0, 1'b0, WH + 8);
      @(posedge mclk_in);
      pull_low <= 1'b1;
      @(posedge mclk_in);
      pull_low <= 1'b0;
      #1;
      chk("pin", {oe, pin_n, pin_o}, 8'h04);
      wait_for(0, 1'b0, WH + 8);
      chk("pin", pin_n, 8'h01);
      pulse(156'h1 << PL);
      chk("hiz", {hiz, err}, 8'h03);
      pulse(156'h1 << PE);
      chk("hiz", {hiz, err}, 8'h00);
      pulse(156'h1 << PC);
      chk("power down", {pdr, resp}, 8'h0D);
      wait_for(2, 1'b0, 20);
      chk("warm", oe, 8'h01);
      wait_for(0, 1'b0, 40);
      step(1);
      chk("phase", ph, 8'h05);
      close_out();
   end
endmodule
